//--- core/stm_pkg.sv
// Purpose: Shared constants for the sync timing measurement block.
// Assumes: 10 MHz system clock, 8-bit register port.
// Notes: Counts derive from times so a clock change is one edit.
package stm_pkg;

	////////////////////////////////////////////////////////////////////
	// Timing.
	localparam int STM_CLK_PERIOD_NS = 100;
	localparam int STM_GLITCH_NS = 125;
	localparam int STM_GLITCH_CYC =
		(STM_GLITCH_NS + STM_CLK_PERIOD_NS - 1) / STM_CLK_PERIOD_NS;
	localparam int STM_TICK_NS = 8000;
	localparam int STM_TICK_CYC = STM_TICK_NS / STM_CLK_PERIOD_NS;
	localparam int STM_WIN_SHORT_US = 16384;
	localparam int STM_WIN_LONG_US = 32768;
	localparam int STM_WIN_SHORT_TICKS =
		STM_WIN_SHORT_US * 1000 / STM_TICK_NS;
	localparam int STM_WIN_LONG_TICKS =
		STM_WIN_LONG_US * 1000 / STM_TICK_NS;
	localparam int STM_VSEP_NS = 20000;
	localparam int STM_VSEP_CYC = STM_VSEP_NS / STM_CLK_PERIOD_NS;

	////////////////////////////////////////////////////////////////////
	// Widths.
	localparam int STM_CNT_W = 14;
	localparam int STM_WIN_W = 12;
	localparam int STM_TICK_W = 7;
	localparam int STM_GCNT_W = 2;
	localparam int STM_SEP_W = 8;
	localparam int STM_ADDR_W = 3;
	localparam int STM_DATA_W = 8;

	////////////////////////////////////////////////////////////////////
	// Register map.
	localparam logic [2:0] STM_VERT_LOW_ADDR = 3'h0;
	localparam logic [2:0] STM_VERT_HIGH_ADDR = 3'h1;
	localparam logic [2:0] STM_HORIZ_LOW_ADDR = 3'h2;
	localparam logic [2:0] STM_HORIZ_HIGH_ADDR = 3'h3;
	localparam logic [2:0] STM_CTRL_ADDR = 3'h4;

	// High result byte: bit 7 overflow flag (write one clears it).
	localparam int STM_OVF_BIT = 7;
	// Control register fields.
	localparam int STM_LEN_BIT = 0;
	localparam int STM_SRC_BIT = 1;
	localparam int STM_SEPARATE_BIT = 2;

	localparam logic STM_LEN_RST = 1'b1;
	localparam logic STM_SRC_RST = 1'b1;
	localparam logic STM_SEPARATE_RST = 1'b1;

endpackage : stm_pkg

//--- core/stm_deglitch.sv
// Purpose: Synchronise one sync pin and drop pulses shorter than 125 ns.
// Assumes: Pin is asynchronous to sys_clk_i.
// Notes: Adds four to five cycles of latency to every edge.
`timescale 1ns/100ps
module stm_deglitch
	import stm_pkg::*;
(
	// Clock and reset.
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	// Pin side.
	input wire logic pin_i,
	// Filtered side.
	output logic level_o,
	output logic rise_o,
	output logic fall_o
);
	import stm_pkg::*;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic lvl;
		logic rise;
		logic fall;
		logic [STM_GCNT_W-1:0] cnt;
	} stm_dg_state_t;

	stm_dg_state_t st_r;
	stm_dg_state_t st_nxt;

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.s1 = pin_i;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		st_nxt.rise = 1'b0;
		st_nxt.fall = 1'b0;
		if (st_r.s2 == st_r.s3 && st_r.s3 != st_r.lvl)
		begin
			if (st_r.cnt >= STM_GCNT_W'(STM_GLITCH_CYC - 1))
			begin
				st_nxt.lvl = st_r.s3;
				st_nxt.rise = st_r.s3;
				st_nxt.fall = ~st_r.s3;
				st_nxt.cnt = '0;
			end
			else
			begin
				st_nxt.cnt = st_r.cnt + STM_GCNT_W'(1);
			end
		end
		else
		begin
			st_nxt.cnt = '0;
		end
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign level_o = st_r.lvl;
	assign rise_o = st_r.rise;
	assign fall_o = st_r.fall;

	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!arst_n_i);

	a_glitch_min_width: assert property (
		$changed(st_r.lvl) |-> $past(st_r.s3, 1) == st_r.lvl
			&& $past(st_r.s3, 2) == st_r.lvl)
		else $error("Filtered level moved on a too short pulse.");

endmodule : stm_deglitch

//--- core/stm_separator.sv
// Purpose: Split a composite sync into horizontal and vertical events.
// Assumes: Filtered sync, active high; short pulses are horizontal.
// Notes: Horizontal events come at the end of a short pulse, so each
// horizontal event lags its pulse by the pulse width.
`timescale 1ns/100ps
module stm_separator
	import stm_pkg::*;
(
	// Clock and reset.
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	// Filtered composite sync.
	input wire logic level_i,
	input wire logic fall_i,
	// Extracted events.
	output logic horiz_pulse_o,
	output logic vert_pulse_o
);
	import stm_pkg::*;

	typedef struct packed {
		logic [STM_SEP_W-1:0] width;
		logic long_seen;
		logic hp;
		logic vp;
	} stm_sep_state_t;

	stm_sep_state_t st_r;
	stm_sep_state_t st_nxt;

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.hp = 1'b0;
		st_nxt.vp = 1'b0;
		if (level_i)
		begin
			if (st_r.width == STM_SEP_W'(STM_VSEP_CYC - 1) && !st_r.long_seen)
			begin
				st_nxt.vp = 1'b1;
				st_nxt.long_seen = 1'b1;
			end
			else if (st_r.width != STM_SEP_W'(STM_VSEP_CYC - 1))
			begin
				st_nxt.width = st_r.width + STM_SEP_W'(1);
			end
		end
		else
		begin
			st_nxt.width = '0;
			st_nxt.long_seen = 1'b0;
		end
		if (fall_i && !st_r.long_seen)
			st_nxt.hp = 1'b1;
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign horiz_pulse_o = st_r.hp;
	assign vert_pulse_o = st_r.vp;

endmodule : stm_separator

//--- core/stm_sync_measure.sv
// Purpose: Measure vertical period and horizontal pulse count of sync.
// Assumes: Syncs are active high after the pin filters.
// Notes: Results are read over a simple 8-bit strobe port.
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////
module stm_sync_measure
	import stm_pkg::*;
#(
	parameter int WIN_SHORT_TICKS = STM_WIN_SHORT_TICKS,
	parameter int WIN_LONG_TICKS = STM_WIN_LONG_TICKS
)
(
	// Clock and reset.
	input wire logic sys_clk_i,
	input wire logic arst_n_i,
	// Sync pins.
	input wire logic horiz_sync_in_i,
	input wire logic vert_sync_in_i,
	// Register port.
	input wire logic [stm_pkg::STM_ADDR_W-1:0] reg_addr_i,
	input wire logic [stm_pkg::STM_DATA_W-1:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [stm_pkg::STM_DATA_W-1:0] reg_rdata_o
);
	import stm_pkg::*;

	localparam logic [STM_CNT_W-1:0] CNT_MAX = '1;

	typedef struct packed {
		logic [STM_TICK_W-1:0] tick_cnt;
		logic [STM_WIN_W-1:0] win_cnt;
		logic [STM_CNT_W-1:0] vert_cnt;
		logic [STM_CNT_W-1:0] vert_period_count;
		logic vert_overflow_flag;
		logic [STM_CNT_W-1:0] horiz_cnt;
		logic [STM_CNT_W-1:0] horiz_pulse_count;
		logic horiz_overflow_flag;
		logic window_source_select_n;
		logic fixed_window_length_bit;
		logic separate_sync;
		logic [STM_DATA_W-1:0] rdata;
	} stm_state_t;

	stm_state_t st_r;
	stm_state_t st_nxt;

	logic h_level;
	logic h_rise;
	logic h_fall;
	logic v_rise;
	logic sep_h;
	logic sep_v;

	////////////////////////////////////////////////////////////////////
	// Pin filters and composite separator.

	stm_deglitch u_horiz_filter (
		.sys_clk_i (sys_clk_i),
		.arst_n_i (arst_n_i),
		.pin_i (horiz_sync_in_i),
		.level_o (h_level),
		.rise_o (h_rise),
		.fall_o (h_fall)
	);

	stm_deglitch u_vert_filter (
		.sys_clk_i (sys_clk_i),
		.arst_n_i (arst_n_i),
		.pin_i (vert_sync_in_i),
		.level_o (),
		.rise_o (v_rise),
		.fall_o ()
	);

	stm_separator u_separator (
		.sys_clk_i (sys_clk_i),
		.arst_n_i (arst_n_i),
		.level_i (h_level),
		.fall_i (h_fall),
		.horiz_pulse_o (sep_h),
		.vert_pulse_o (sep_v)
	);

	////////////////////////////////////////////////////////////////////
	// Measurement and register logic.

	logic tick;
	logic v_ev;
	logic h_ev;
	logic win_end;
	logic h_latch;
	logic [STM_WIN_W-1:0] win_last;
	logic vert_clr;
	logic horiz_clr;
	logic vert_set;
	logic horiz_set;

	always_comb
	begin
		st_nxt = st_r;
		v_ev = st_r.separate_sync ? v_rise : sep_v;
		h_ev = st_r.separate_sync ? h_rise : sep_h;

		tick = (st_r.tick_cnt == STM_TICK_W'(STM_TICK_CYC - 1));
		st_nxt.tick_cnt = tick ? '0 : st_r.tick_cnt + STM_TICK_W'(1);

		win_last = st_r.fixed_window_length_bit ?
			STM_WIN_W'(WIN_LONG_TICKS - 1) :
			STM_WIN_W'(WIN_SHORT_TICKS - 1);
		win_end = !st_r.window_source_select_n && tick
			&& st_r.win_cnt == win_last;
		if (st_r.window_source_select_n)
			st_nxt.win_cnt = '0;
		else if (tick)
			st_nxt.win_cnt = win_end ? '0 : st_r.win_cnt + STM_WIN_W'(1);

		vert_clr = reg_wr_i && reg_addr_i == STM_VERT_HIGH_ADDR
			&& reg_wdata_i[STM_OVF_BIT];
		horiz_clr = reg_wr_i && reg_addr_i == STM_HORIZ_HIGH_ADDR
			&& reg_wdata_i[STM_OVF_BIT];
		vert_set = 1'b0;
		horiz_set = 1'b0;

		// vertical counter steps once per tick
		// latch and restart on vertical pulse
		// A tick that lands on the latching edge is dropped, so the period
		// then reads one tick short; the latch stays a single cycle.
		if (v_ev)
		begin
			st_nxt.vert_period_count = st_r.vert_cnt;
			st_nxt.vert_cnt = '0;
		end
		else if (tick)
		begin
			if (st_r.vert_cnt == CNT_MAX)
				vert_set = 1'b1;
			else
				st_nxt.vert_cnt = st_r.vert_cnt + STM_CNT_W'(1);
		end

		h_latch = st_r.window_source_select_n ? v_ev : win_end;
		if (h_latch)
		begin
			st_nxt.horiz_pulse_count = st_r.horiz_cnt;
			st_nxt.horiz_cnt = h_ev ? STM_CNT_W'(1) : '0;
		end
		else if (h_ev)
		begin
			if (st_r.horiz_cnt == CNT_MAX)
				horiz_set = 1'b1;
			else
				st_nxt.horiz_cnt = st_r.horiz_cnt + STM_CNT_W'(1);
		end

		// sticky flag, set wins over clear
		st_nxt.vert_overflow_flag = vert_set
			|| (st_r.vert_overflow_flag && !vert_clr);
		st_nxt.horiz_overflow_flag = horiz_set
			|| (st_r.horiz_overflow_flag && !horiz_clr);

		if (reg_wr_i && reg_addr_i == STM_CTRL_ADDR)
		begin
			st_nxt.fixed_window_length_bit = reg_wdata_i[STM_LEN_BIT];
			st_nxt.window_source_select_n = reg_wdata_i[STM_SRC_BIT];
			st_nxt.separate_sync = reg_wdata_i[STM_SEPARATE_BIT];
		end

		st_nxt.rdata = '0;
		if (reg_rd_i)
		begin
			unique case (reg_addr_i)
				STM_VERT_LOW_ADDR:
					st_nxt.rdata = st_r.vert_period_count[7:0];
				STM_VERT_HIGH_ADDR:
					st_nxt.rdata = {st_r.vert_overflow_flag, 1'b0,
						st_r.vert_period_count[STM_CNT_W-1:8]};
				STM_HORIZ_LOW_ADDR:
					st_nxt.rdata = st_r.horiz_pulse_count[7:0];
				STM_HORIZ_HIGH_ADDR:
					st_nxt.rdata = {st_r.horiz_overflow_flag, 1'b0,
						st_r.horiz_pulse_count[STM_CNT_W-1:8]};
				STM_CTRL_ADDR:
					st_nxt.rdata = {5'h00, st_r.separate_sync,
						st_r.window_source_select_n,
						st_r.fixed_window_length_bit};
				default:
					st_nxt.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge sys_clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			st_r <= '0;
			st_r.window_source_select_n <= STM_SRC_RST;
			st_r.fixed_window_length_bit <= STM_LEN_RST;
			st_r.separate_sync <= STM_SEPARATE_RST;
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	assign reg_rdata_o = st_r.rdata;

	////////////////////////////////////////////////////////////////////
	// Checks.

	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!arst_n_i);

	a_vert_latch_copy: assert property (
		v_ev |=> st_r.vert_period_count == $past(st_r.vert_cnt)
			&& st_r.vert_cnt == '0)
		else $error("Vertical result did not take the running count.");

	a_vert_tick_step: assert property (
		(tick && !v_ev && st_r.vert_cnt != CNT_MAX)
			|=> st_r.vert_cnt == $past(st_r.vert_cnt) + STM_CNT_W'(1))
		else $error("Vertical counter missed a tick.");

	a_vert_no_tick: assert property (
		(!tick && !v_ev) |=> $stable(st_r.vert_cnt))
		else $error("Vertical counter moved between ticks.");

	a_vert_ovf_set: assert property (
		(tick && !v_ev && st_r.vert_cnt == CNT_MAX)
			|=> st_r.vert_overflow_flag && st_r.vert_cnt == CNT_MAX)
		else $error("Vertical overflow not flagged or count wrapped.");

	a_vert_ovf_hold: assert property (
		(st_r.vert_overflow_flag && !vert_clr) |=> st_r.vert_overflow_flag)
		else $error("Vertical overflow flag dropped without a clear.");

	a_vert_read_only: assert property (
		(reg_wr_i && !v_ev) |=> $stable(st_r.vert_period_count))
		else $error("A write changed the vertical result.");

	a_horiz_clear_keep: assert property (
		(horiz_clr && !h_latch && !h_ev) |=> $stable(st_r.horiz_cnt))
		else $error("Clearing horizontal overflow touched the count.");

	a_horiz_win_latch: assert property (
		win_end |=> st_r.horiz_pulse_count == $past(st_r.horiz_cnt))
		else $error("Horizontal result not latched at window end.");

	a_horiz_vert_latch: assert property (
		(st_r.window_source_select_n && v_ev)
			|=> st_r.horiz_pulse_count == $past(st_r.horiz_cnt))
		else $error("Horizontal result not latched at vertical pulse.");

	a_horiz_cnt_step: assert property (
		(h_ev && !h_latch && st_r.horiz_cnt != CNT_MAX)
			|=> st_r.horiz_cnt == $past(st_r.horiz_cnt) + STM_CNT_W'(1))
		else $error("Horizontal counter missed a pulse.");

	a_horiz_ovf_set: assert property (
		(h_ev && !h_latch && st_r.horiz_cnt == CNT_MAX)
			|=> st_r.horiz_overflow_flag && st_r.horiz_cnt == CNT_MAX)
		else $error("Horizontal overflow not flagged or count wrapped.");

	a_horiz_ovf_hold: assert property (
		(st_r.horiz_overflow_flag && !horiz_clr)
			|=> st_r.horiz_overflow_flag)
		else $error("Horizontal overflow flag dropped without a clear.");

	a_vert_ovf_clear: assert property (
		(vert_clr && !vert_set) |=> !st_r.vert_overflow_flag)
		else $error("Vertical overflow flag survived a clear.");

	a_rdata_idle_zero: assert property (
		!reg_rd_i |=> reg_rdata_o == '0)
		else $error("Read data showed outside a read.");

endmodule : stm_sync_measure

//--- dv/stm_sync_source.sv
// Purpose: Model of the video source driving both sync pins.
// Assumes: Syncs are active high and change just after a rising edge.
// Notes: One frame() call lasts ticks*80 clocks and, in modes 0 and 1, starts a new period.
`timescale 1ns/100ps
module stm_sync_source
(
	// Clock.
	input wire logic sys_clk_i,
	// Sync pins.
	output logic horiz_sync_o,
	output logic vert_sync_o
);
	initial
	begin
		horiz_sync_o = 1'b0;
		vert_sync_o = 1'b0;
	end

	////////////////////////////////////////////////////////////////////
	// Mode 0 is separate sync, 1 composite, 2 a bare horizontal train.
	// Pulses sit well clear of the vertical edge so counts stay exact.
	task automatic frame(input int ticks, input int nh, input int mode,
		input bit glitch);
		int base;
		int k;
		bit hp;
		bit gl;
		base = (mode == 1) ? 260 : 20;
		for (int c = 0; c < ticks * 80; c++)
		begin
			@(posedge sys_clk_i);
			k = c - base;
			hp = (k >= 0) && (k / 20 < nh) && (k % 20 < 4);
			if (mode == 2)
				hp = (c % 20) < 4;
			gl = glitch && (k >= 0) && (k % 20 == 10);
			horiz_sync_o <= hp | gl | ((mode == 1) && (c < 240));
			vert_sync_o <= (mode == 0) && ((c < 4) || (glitch && c == 40));
		end
	endtask : frame
endmodule : stm_sync_source

//--- dv/tb_top.sv
// Purpose: Self-checking bench for the sync timing measurement block.
// Assumes: Fixed windows shortened to 4 and 8 ticks.
// Notes: Overflow needs over 16383 ticks or horizontal pulses, so it is not exercised.
`timescale 1ns/100ps
module tb_top;
	import stm_pkg::*;
	localparam int LONG_W = 8;
	logic sys_clk = 1'b0;
	logic arst_n = 1'b0;
	logic horiz_sync;
	logic vert_sync;
	logic [2:0] addr = 3'h0;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] rdata;
	int err_total = 0;
	int tests_run = 0;
	// Frames start 14 edges after a tick edge, so no vertical event ever
	// shares its edge with a tick and every period counts whole ticks.
	localparam int TICK_PHASE = 18;
	int cyc = 0;

	always #50 sys_clk = ~sys_clk;

	always @(posedge sys_clk)
		cyc <= cyc + 1;

	stm_sync_measure #(
		.WIN_SHORT_TICKS(LONG_W / 2),
		.WIN_LONG_TICKS(LONG_W)
	) dut (
		.sys_clk_i(sys_clk),
		.arst_n_i(arst_n),
		.horiz_sync_in_i(horiz_sync),
		.vert_sync_in_i(vert_sync),
		.reg_addr_i(addr),
		.reg_wdata_i(wdata),
		.reg_wr_i(wr),
		.reg_rd_i(rd),
		.reg_rdata_o(rdata)
	);

	stm_sync_source src (
		.sys_clk_i(sys_clk),
		.horiz_sync_o(horiz_sync),
		.vert_sync_o(vert_sync)
	);

	////////////////////////////////////////////////////////////////////
	task automatic tally_and_finish;
		$display("checks %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			err_total++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask : chk

	task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask : wr_reg

	// Data stand only in the cycle after the read edge, taken mid-cycle.
	task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
		@(posedge sys_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge sys_clk);
		rd <= 1'b0;
		@(negedge sys_clk);
		chk(rdata, exp);
	endtask : rd_chk

	// One measured period, then a short one whose edge latches it.
	task automatic measure(input int vt, input int nh, input int mode,
		input bit glitch);
		do
			@(posedge sys_clk);
		while (cyc % STM_TICK_CYC != TICK_PHASE);
		src.frame(vt, nh, mode, glitch);
		src.frame((mode == 1) ? 4 : 1, 0, mode, 1'b0);
		rd_chk(STM_VERT_LOW_ADDR, 8'(vt));
		rd_chk(STM_VERT_HIGH_ADDR, 8'(vt >> 8));
		rd_chk(STM_HORIZ_LOW_ADDR, 8'(nh));
		rd_chk(STM_HORIZ_HIGH_ADDR, 8'(nh >> 8));
	endtask : measure

	////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (40000) @(posedge sys_clk);
		err_total++;
		tally_and_finish();
	end

	initial
	begin
		repeat (6) @(posedge sys_clk);
		arst_n <= 1'b1;
		for (int a = 0; a < 8; a++)
			rd_chk(3'(a), (a == 4) ? 8'h07 : 8'h00);
		for (int a = 0; a < 6; a++)
			if (a != 4)
				wr_reg(3'(a), 8'h7f);
		for (int a = 0; a < 6; a++)
			if (a != 4)
				rd_chk(3'(a), 8'h00);
		wr_reg(STM_CTRL_ADDR, 8'h06);
		rd_chk(STM_CTRL_ADDR, 8'h06);
		measure(8, 20, 0, 1'b0);
		wr_reg(STM_CTRL_ADDR, 8'h07);
		// Glitches on both pins, and flag clears in mid-period.
		fork
			measure(260, 300, 0, 1'b1);
			begin
				repeat (3000) @(posedge sys_clk);
				wr_reg(STM_HORIZ_HIGH_ADDR, 8'h80);
				wr_reg(STM_VERT_HIGH_ADDR, 8'h80);
			end
		join
		wr_reg(STM_CTRL_ADDR, 8'h05);
		src.frame(3 * LONG_W, 0, 2, 1'b0);
		rd_chk(STM_HORIZ_LOW_ADDR, 8'(LONG_W * 4));
		rd_chk(STM_HORIZ_HIGH_ADDR, 8'h00);
		wr_reg(STM_CTRL_ADDR, 8'h03);
		measure(8, 12, 1, 1'b0);
		tally_and_finish();
	end
endmodule : tb_top
